// ==== dv/clockgen_model.sv ====
// behavioural clock generator that feeds the glue block and samples its ready line
`timescale 1ns/1ns

module clockgen_model #(
  parameter int HALF = 4
) (
  input wire logic core_clk_i,
  input wire logic ready_i,
  output logic gen_clk_o,
  output logic ready_seen_o
);
  int cnt = 0;

  // free running, as the real generator never stops; slow against the core clock
  initial gen_clk_o = 1'b0;
  initial ready_seen_o = 1'b1;

  always @(negedge core_clk_i) begin
    cnt = (cnt + 1) % HALF;
    if (cnt == 0) begin
      gen_clk_o <= ~gen_clk_o;
      if (!gen_clk_o) begin
        ready_seen_o <= ready_i;
      end
    end
  end
endmodule : clockgen_model

// ==== dv/testbench.sv ====
// self-checking bench for the memory decode, clock gating and wait-state glue
`timescale 1ns/1ns
`include "glue_map.svh"

module testbench;
  import glue_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic pd = 1'b0;
  logic st = 1'b0;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic slow_n = 1'b1;
  logic ale = 1'b0;
  logic gen_clk;
  logic seen;
  logic [3:0] ram_n;
  logic rom_n;
  logic hold;
  logic pclk;
  logic rdy;
  int err_count = 0;
  int comparisons = 0;

  always #25 core_clk = ~core_clk;

  clockgen_model #(.HALF(4)) gen (.core_clk_i(core_clk), .ready_i(rdy), .gen_clk_o(gen_clk), .ready_seen_o(seen));

  memory_decode_clkgate_wait #(.RAM_BANKS(`RAM_BANKS)) dut (
    .core_clk_i(core_clk), .rstn_i(rstn), .address_bit_high_i(addr[2]), .address_bit_mid_i(addr[1]),
    .address_bit_low_i(addr[0]), .power_down_request_i(pd), .memory_cycle_status_i(st),
    .memory_read_strobe_n_i(rd_n), .advanced_write_strobe_n_i(wr_n), .slow_region_select_n_i(slow_n),
    .address_latch_strobe_i(ale), .clockgen_clk_i(gen_clk), .ram_select_n_o(ram_n),
    .eprom_select_n_o(rom_n), .clock_hold_flop_o(hold), .processor_clk_o(pclk), .clockgen_ready_out_o(rdy));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_sim;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk_vec(input logic [4:0] got, input logic [4:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: selects %b expected %b", $time, got, exp);
    end
  endtask : chk_vec

  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // bounded wait on ready or on the hold flop
  task automatic wait_flag(input logic use_rdy, input logic v);
    int n;
    for (n = 0; n < 40 && (use_rdy ? rdy : hold) !== v; n++) @(negedge core_clk);
    if (n == 40) begin
      err_count++;
      $display("mismatch at %0t: wait ran out", $time);
      end_sim();
    end
  endtask : wait_flag

  task automatic drive(input logic [2:0] a, input logic p, input logic s, input logic r, input logic w);
    @(negedge core_clk);
    addr = a;
    pd = p;
    st = s;
    rd_n = r;
    wr_n = w;
  endtask : drive

  function automatic logic [4:0] exp_sel(input logic [2:0] a, input logic p, input logic s, input logic r,
                                         input logic w);
    logic en;
    en = !p && s;
    exp_sel = 5'h1f;
    exp_sel[4] = !(en && a[2]);
    if (!a[2]) exp_sel[a[1:0]] = !(en && (!r || !w));
  endfunction : exp_sel

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // modes: read, write, no strobe, read with an io cycle
  task automatic t_decode;
    for (int m = 0; m < 4; m++) begin
      for (int a = 0; a < 8; a++) begin
        drive(3'(a), 1'b0, m != 3, m == 1 || m == 2, m != 1);
        repeat (6) @(negedge core_clk);
        chk_vec({rom_n, ram_n}, exp_sel(addr, pd, st, rd_n, wr_n));
      end
    end
  endtask : t_decode

  task automatic t_gate;
    int run;
    int lo;
    int hi;
    int n;
    logic prev;
    drive(3'h4, 1'b1, 1'b1, 1'b0, 1'b1);
    wait_flag(1'b0, 1'b1);
    repeat (6) @(negedge core_clk);
    chk_vec({rom_n, ram_n}, 5'h1f);
    for (int k = 0; k < 16; k++) begin
      @(negedge core_clk);
      chk_bit(pclk, 1'b1);
    end
    drive(3'h4, 1'b0, 1'b1, 1'b0, 1'b1);
    wait_flag(1'b0, 1'b0);
    // the first run is cut by the window start, so it is not measured
    run = 0;
    lo = 99;
    hi = 0;
    n = 0;
    prev = pclk;
    for (int k = 0; k < 40; k++) begin
      @(negedge core_clk);
      run++;
      if (pclk !== prev) begin
        if (n > 0 && run < lo) lo = run;
        if (n > 0 && run > hi) hi = run;
        n++;
        run = 0;
        prev = pclk;
      end
    end
    chk_bit(lo == 4 && hi == 4, 1'b1);
  endtask : t_gate

  task automatic t_wait;
    logic prev;
    logic gprev;
    @(negedge core_clk);
    ale = 1'b1;
    repeat (3) @(negedge core_clk);
    ale = 1'b0;
    repeat (10) @(negedge core_clk);
    chk_bit(rdy, 1'b1);
    // start just after a generator rise so its next sampling edge falls inside the wait window
    gprev = 1'b1;
    for (int k = 0; k < 20 && !(gen_clk === 1'b1 && gprev === 1'b0); k++) begin
      gprev = gen_clk;
      @(negedge core_clk);
    end
    chk_bit(seen, 1'b1);
    ale = 1'b1;
    slow_n = 1'b0;
    repeat (3) @(negedge core_clk);
    ale = 1'b0;
    slow_n = 1'b1;
    wait_flag(1'b1, 1'b0);
    prev = pclk;
    for (int k = 0; k < 40 && rdy !== 1'b1; k++) begin
      prev = pclk;
      @(negedge core_clk);
    end
    chk_bit(rdy, 1'b1);
    chk_bit(pclk & ~prev, 1'b1);
    chk_bit(seen, 1'b0);
  endtask : t_wait

  initial begin
    repeat (3) @(negedge core_clk);
    chk_vec({rom_n, ram_n}, 5'h1f);
    chk_bit(pclk, 1'b0);
    rstn = 1'b1;
    @(negedge core_clk);
    chk_bit(hold, 1'b0);
    chk_bit(rdy, 1'b1);
    t_decode();
    t_gate();
    t_wait();
    end_sim();
  end
endmodule : testbench

// ==== src/glue_map.svh ====
// constants for the memory decode, clock gating and wait-state glue
`ifndef GLUE_MAP_SVH
`define GLUE_MAP_SVH

// ----------------------------------------
// pin input vector layout
// ----------------------------------------
`define PIN_W 10
`define PIN_ADDR_LOW 0
`define PIN_ADDR_MID 1
`define PIN_ADDR_HIGH 2
`define PIN_PWR_DOWN 3
`define PIN_MEM_STATUS 4
`define PIN_RD_N 5
`define PIN_WR_N 6
`define PIN_SLOW_N 7
`define PIN_ALE 8
`define PIN_GEN_CLK 9

// ----------------------------------------
// reset values
// ----------------------------------------
// strobes and slow select idle high, everything else low
`define PIN_RESET 10'h0e0
`define RAM_CS_RESET 4'hf
`define EPROM_CS_RESET 1'h1
`define HOLD_RESET 1'h0
`define READY_RESET 1'h1
`define PROC_CLK_RESET 1'h0

// ----------------------------------------
// decode sizes
// ----------------------------------------
`define RAM_BANKS 4
`define REGION_COUNT 8

`endif

// ==== src/glue_pkg.sv ====
// types shared by the memory decode, clock gating and wait-state glue
`include "glue_map.svh"

package glue_pkg;

  typedef logic [`PIN_W-1:0] pin_vec_type;
  typedef logic [`REGION_COUNT-1:0] region_vec_type;
  typedef logic [2:0] region_index_type;

endpackage : glue_pkg

// ==== src/memory_decode_clkgate_wait.sv ====
// memory chip-select decoder, processor clock gating and single wait-state generator
// ----------------------------------------
// Function
// - selects for one 32K EPROM bank and four 4K static RAM banks.
// - only address bits 19, 13 and 12 are decoded; others ignored.
// - three-to-eight decoder, output low when index matches and enable true.
// - decode enable true only with power-down low and memory status high.
// - RAM selects also need read strobe or advanced write strobe active.
// - EPROM select low when bit 19 high and enable true.
// - with power-down low, hold flop is zero and processor clock follows generator.
// - power-down high sets hold flop at next generator rising edge, clock stays high.
// - clock stays high until power-down low and a later generator rise clears hold.
// - gating changes only at generator rising edges, no partial clock cycles.
// - address latch strobe with slow-region select low clears ready output.
// - rising processor clock edge in T2 sets ready high, one wait state only.
// - wait flop built as D register with feedback, same as JK behaviour.
// ----------------------------------------
`timescale 1ns/1ns

module memory_decode_clkgate_wait
  import glue_pkg::*;
#(
  parameter int RAM_BANKS = `RAM_BANKS
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic address_bit_high_i,
  input wire logic address_bit_mid_i,
  input wire logic address_bit_low_i,
  input wire logic power_down_request_i,
  input wire logic memory_cycle_status_i,
  input wire logic memory_read_strobe_n_i,
  input wire logic advanced_write_strobe_n_i,
  input wire logic slow_region_select_n_i,
  input wire logic address_latch_strobe_i,
  input wire logic clockgen_clk_i,
  output logic [`RAM_BANKS-1:0] ram_select_n_o,
  output logic eprom_select_n_o,
  output logic clock_hold_flop_o,
  output logic processor_clk_o,
  output logic clockgen_ready_out_o
);

  // the decoder is laid out for exactly four RAM banks
  if (RAM_BANKS != `RAM_BANKS) begin : g_bank_check
    $error("RAM_BANKS must equal four");
  end

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // active-low one-of-eight decode, bit 19 is the index msb
  function automatic region_vec_type region_decode(input region_index_type idx, input logic en);
    region_vec_type r;
    r = '1;
    if (en) begin
      r[idx] = 1'b0;
    end
    return r;
  endfunction : region_decode

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // three stages; a pin change counts only once stages two and three agree,
  // which costs latency but rejects single-sample glitches
  pin_vec_type pins;
  pin_vec_type s1_q, s1_d;
  pin_vec_type s2_q, s2_d;
  pin_vec_type s3_q, s3_d;
  pin_vec_type filt_q, filt_d;
  pin_vec_type agree;

  assign pins = {clockgen_clk_i, address_latch_strobe_i, slow_region_select_n_i,
                 advanced_write_strobe_n_i, memory_read_strobe_n_i, memory_cycle_status_i,
                 power_down_request_i, address_bit_high_i, address_bit_mid_i, address_bit_low_i};

  always_comb begin
    s1_d = pins;
    s2_d = s1_q;
    s3_d = s2_q;
    agree = ~(s2_q ^ s3_q);
    filt_d = (s3_q & agree) | (filt_q & ~agree);
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      s1_q <= `PIN_RESET;
      s2_q <= `PIN_RESET;
      s3_q <= `PIN_RESET;
      filt_q <= `PIN_RESET;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      filt_q <= filt_d;
    end
  end

  logic addr_high, addr_mid, addr_low, pwr_down, mem_status;
  logic rd_n, wr_n, slow_n, ale, gen_clk, gen_clk_prev_q;

  assign addr_high = filt_q[`PIN_ADDR_HIGH];
  assign addr_mid = filt_q[`PIN_ADDR_MID];
  assign addr_low = filt_q[`PIN_ADDR_LOW];
  assign pwr_down = filt_q[`PIN_PWR_DOWN];
  assign mem_status = filt_q[`PIN_MEM_STATUS];
  assign rd_n = filt_q[`PIN_RD_N];
  assign wr_n = filt_q[`PIN_WR_N];
  assign slow_n = filt_q[`PIN_SLOW_N];
  assign ale = filt_q[`PIN_ALE];
  assign gen_clk = filt_q[`PIN_GEN_CLK];

  // ----------------------------------------
  // memory decode
  // ----------------------------------------
  logic decode_en;
  logic strobe_act;
  region_vec_type region_select_n;
  logic [`RAM_BANKS-1:0] ram_sel_n_q, ram_sel_n_d;
  logic eprom_sel_n_q, eprom_sel_n_d;

  always_comb begin
    decode_en = !pwr_down && mem_status;
    // only three address bits reach the decoder
    region_select_n = region_decode({addr_high, addr_mid, addr_low}, decode_en);
    // ram without output enable must not drive during the address phase
    strobe_act = !rd_n || !wr_n;
    ram_sel_n_d = region_select_n[`RAM_BANKS-1:0] | {`RAM_BANKS{!strobe_act}};
    eprom_sel_n_d = &region_select_n[`REGION_COUNT-1:`RAM_BANKS];
  end

  // indices 0..3 are the RAM banks, 4..7 fold into the one EPROM
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ram_sel_n_q <= `RAM_CS_RESET;
      eprom_sel_n_q <= `EPROM_CS_RESET;
    end else begin
      ram_sel_n_q <= ram_sel_n_d;
      eprom_sel_n_q <= eprom_sel_n_d;
    end
  end

  // ----------------------------------------
  // processor clock gating
  // ----------------------------------------
  logic gen_rise;
  logic hold_q, hold_d;
  logic proc_clk_q, proc_clk_d;

  always_comb begin
    gen_rise = gen_clk && !gen_clk_prev_q;
    // hold only moves while the generator clock is high, so the or never glitches
    hold_d = gen_rise ? pwr_down : hold_q;
    proc_clk_d = gen_clk || hold_d;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      gen_clk_prev_q <= 1'h0;
      hold_q <= `HOLD_RESET;
      proc_clk_q <= `PROC_CLK_RESET;
    end else begin
      gen_clk_prev_q <= gen_clk;
      hold_q <= hold_d;
      proc_clk_q <= proc_clk_d;
    end
  end

  // ----------------------------------------
  // single wait-state generator
  // ----------------------------------------
  // the generator samples ready in T2; a low level there adds one wait
  logic proc_rise;
  logic wait_clear;
  logic ready_q, ready_d;

  always_comb begin
    proc_rise = proc_clk_d && !proc_clk_q;
    wait_clear = ale && !slow_n;
    // d flop with feedback: clear dominates, else set on the next processor rise
    if (wait_clear) begin
      ready_d = 1'b0;
    end else if (proc_rise) begin
      ready_d = 1'b1;
    end else begin
      ready_d = ready_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ready_q <= `READY_RESET;
    end else begin
      ready_q <= ready_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign ram_select_n_o = ram_sel_n_q;
  assign eprom_select_n_o = eprom_sel_n_q;
  assign clock_hold_flop_o = hold_q;
  assign processor_clk_o = proc_clk_q;
  assign clockgen_ready_out_o = ready_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_wait_cleared;
    wait_clear ##1 !ready_q;
  endsequence

  sequence s_release;
    !ready_q && !wait_clear && proc_rise;
  endsequence

  property p_one_ram;
    $countones(~ram_sel_n_q) <= 1 && !(eprom_sel_n_q == 1'b0 && ram_sel_n_q != '1);
  endproperty
  a_one_ram: assert property (p_one_ram) else $error("more than one memory selected");

  property p_pdown_blocks;
    pwr_down |=> ram_sel_n_q == '1 && eprom_sel_n_q;
  endproperty
  a_pdown_blocks: assert property (p_pdown_blocks) else $error("select active during power down");

  property p_ram_needs_strobe;
    (rd_n && wr_n) |=> ram_sel_n_q == '1;
  endproperty
  a_ram_needs_strobe: assert property (p_ram_needs_strobe) else $error("ram selected without strobe");

  property p_eprom_hit;
    (addr_high && !pwr_down && mem_status) |=> !eprom_sel_n_q;
  endproperty
  a_eprom_hit: assert property (p_eprom_hit) else $error("eprom not selected");

  property p_ram_bank;
    (!addr_high && !pwr_down && mem_status && !rd_n) |=> ram_sel_n_q[{$past(addr_mid), $past(addr_low)}] == 1'h0;
  endproperty
  a_ram_bank: assert property (p_ram_bank) else $error("wrong ram bank selected");

  property p_ram_write;
    (!addr_high && !pwr_down && mem_status && !wr_n) |=> ram_sel_n_q[{$past(addr_mid), $past(addr_low)}] == 1'h0;
  endproperty
  a_ram_write: assert property (p_ram_write) else $error("ram not selected on write");

  property p_eprom_miss;
    !addr_high |=> eprom_sel_n_q;
  endproperty
  a_eprom_miss: assert property (p_eprom_miss) else $error("eprom selected in ram space");

  property p_hold_set;
    (gen_rise && pwr_down) |=> hold_q && proc_clk_q;
  endproperty
  a_hold_set: assert property (p_hold_set) else $error("hold not set on generator rise");

  property p_hold_clear;
    (gen_rise && !pwr_down) |=> !hold_q;
  endproperty
  a_hold_clear: assert property (p_hold_clear) else $error("hold not cleared on generator rise");

  property p_hold_high;
    hold_q |-> proc_clk_q;
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("processor clock low while held");

  property p_clean_edges;
    $changed(hold_q) |-> proc_clk_q && $past(gen_rise);
  endproperty
  a_clean_edges: assert property (p_clean_edges) else $error("hold changed off a generator rise");

  property p_follow;
    (!hold_q && !$past(hold_q)) |-> proc_clk_q == $past(gen_clk);
  endproperty
  a_follow: assert property (p_follow) else $error("processor clock not following generator");

  property p_wait_clear;
    wait_clear |-> s_wait_cleared;
  endproperty
  a_wait_clear: assert property (p_wait_clear) else $error("ready not cleared");

  property p_wait_release;
    s_release |=> ready_q;
  endproperty
  a_wait_release: assert property (p_wait_release) else $error("ready not set on processor rise");

  property p_ready_holds;
    (!ready_q && !wait_clear && !proc_rise) |=> !ready_q;
  endproperty
  a_ready_holds: assert property (p_ready_holds) else $error("ready released before processor rise");

  property p_after_reset;
    !$past(rstn_i) |-> ready_q && !hold_q;
  endproperty
  a_after_reset: assert property (p_after_reset) else $error("bad state after reset");

endmodule : memory_decode_clkgate_wait
